// >>> rtl/scrbk_pkg.sv
`default_nettype none
package scrbk_pkg;
	// ----------------------------------------------------------------
	// Bus encodings
	// ----------------------------------------------------------------
	localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;
	localparam int          ADDR_W        = 12;
	localparam int          CHAN_B_BIT    = 8;

	// ----------------------------------------------------------------
	// Read offsets (per channel, channel B adds 0x100)
	// ----------------------------------------------------------------
	localparam logic [11:0] OFF_RXSTAT    = 12'h004;
	localparam logic [11:0] OFF_VECTOR    = 12'h008;
	localparam logic [11:0] OFF_PEND      = 12'h00C;
	localparam logic [11:0] OFF_MODE_RB   = 12'h010;
	localparam logic [11:0] OFF_TX_RB     = 12'h014;
	localparam logic [11:0] OFF_BCNT      = 12'h018;
	localparam logic [11:0] OFF_RXP_RB    = 12'h024;
	localparam logic [11:0] OFF_MISC_RB   = 12'h038;

	// ----------------------------------------------------------------
	// Write offsets
	// ----------------------------------------------------------------
	localparam logic [11:0] OFF_MODE_WR   = 12'h040;
	localparam logic [11:0] OFF_TXP_WR    = 12'h044;
	localparam logic [11:0] OFF_RXP_WR    = 12'h048;
	localparam logic [11:0] OFF_MISC_WR   = 12'h04C;
	localparam logic [11:0] OFF_EXT_WR    = 12'h050;
	localparam logic [11:0] OFF_VEC_WR    = 12'h054;
	localparam logic [11:0] OFF_IRQ_STAT  = 12'h060;
	localparam logic [11:0] OFF_IRQ_MASK  = 12'h064;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int MODE_CLK_LO  = 6;
	localparam int MODE_SYNC_LO = 4;
	localparam int MODE_STOP_LO = 2;
	localparam int TX_DTR       = 7;
	localparam int TX_LEN_LO    = 5;
	localparam int TX_BRK       = 4;
	localparam int TX_EN        = 3;
	localparam int TX_CRC_SEL   = 2;
	localparam int TX_RTS       = 1;
	localparam int TX_CRC_EN    = 0;
	localparam int EXT_RB_EN    = 6;
	localparam int VEC_STAT_LO  = 1;
	localparam int PEND_W       = 6;
	localparam int PEND_A_RX    = 5;
	localparam int PEND_A_TX    = 4;
	localparam int PEND_A_EXT   = 3;
	localparam int PEND_B_RX    = 2;
	localparam int PEND_B_TX    = 1;
	localparam int PEND_B_EXT   = 0;

	// ----------------------------------------------------------------
	// Reset values and vector status codes
	// ----------------------------------------------------------------
	localparam logic [7:0] RST_CFG  = 8'h00;
	localparam logic [7:0] RST_VEC  = 8'h00;
	localparam logic [5:0] RST_MASK = 6'h00;
	localparam logic [2:0] VST_A_RX  = 3'h6;
	localparam logic [2:0] VST_A_TX  = 3'h4;
	localparam logic [2:0] VST_A_EXT = 3'h5;
	localparam logic [2:0] VST_B_RX  = 3'h2;
	localparam logic [2:0] VST_B_TX  = 3'h0;
	localparam logic [2:0] VST_B_EXT = 3'h1;
	localparam logic [2:0] VST_NONE  = 3'h3;
endpackage
`default_nettype wire

// >>> rtl/scrbk_ahb_slave.sv
`timescale 1ns/1ps
`default_nettype none
module scrbk_ahb_slave (
	input  wire logic                      hclk,
	input  wire logic                      hresetn,
	input  wire logic                      hsel,
	input  wire logic [scrbk_pkg::ADDR_W-1:0] haddr,
	input  wire logic [1:0]                htrans,
	input  wire logic                      hwrite,
	input  wire logic                      hready,
	output logic                           hreadyout,
	output logic                           hresp,
	output logic                           rd_en,
	output logic                           wr_en,
	output logic [scrbk_pkg::ADDR_W-1:0]   wr_addr
);
	import scrbk_pkg::*;

	logic              acc;
	logic              next_wr_en;
	logic [ADDR_W-1:0] next_wr_addr;

	// Zero wait states: the slave never stretches a transfer
	always_comb begin
		acc          = hsel && hready && (htrans == HTRANS_NONSEQ);
		rd_en        = acc && !hwrite;
		next_wr_en   = acc && hwrite;
		next_wr_addr = (acc && hwrite) ? haddr : wr_addr;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_en     <= 1'b0;
			wr_addr   <= '0;
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end else begin
			wr_en     <= next_wr_en;
			wr_addr   <= next_wr_addr;
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end
	end
endmodule
`default_nettype wire

// >>> rtl/scrbk_irq.sv
`timescale 1ns/1ps
`default_nettype none
module scrbk_irq (
	input  wire logic                     hclk,
	input  wire logic                     hresetn,
	input  wire logic [scrbk_pkg::PEND_W-1:0] src,
	input  wire logic                     clr_we,
	input  wire logic                     mask_we,
	input  wire logic [scrbk_pkg::PEND_W-1:0] wdata,
	output logic [scrbk_pkg::PEND_W-1:0]  status,
	output logic [scrbk_pkg::PEND_W-1:0]  mask,
	output logic                          irq
);
	import scrbk_pkg::*;

	logic [PEND_W-1:0] src_q;
	logic [PEND_W-1:0] rise;
	logic [PEND_W-1:0] next_status;
	logic [PEND_W-1:0] next_mask;
	logic              next_irq;

	// A new pending edge in the clearing cycle survives the clear
	always_comb begin
		rise        = src & ~src_q;
		next_status = (status & ~(clr_we ? wdata : '0)) | rise;
		next_mask   = mask_we ? wdata : mask;
		next_irq    = |(next_status & next_mask);
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			src_q  <= '0;
			status <= '0;
			mask   <= RST_MASK;
			irq    <= 1'b0;
		end else begin
			src_q  <= src;
			status <= next_status;
			mask   <= next_mask;
			irq    <= next_irq;
		end
	end
endmodule
`default_nettype wire

// >>> rtl/scrbk_regs.sv
`timescale 1ns/1ps
`default_nettype none
module scrbk_regs (
	input  wire logic                      hclk,
	input  wire logic                      hresetn,
	input  wire logic                      hsel,
	input  wire logic [31:0]               haddr,
	input  wire logic [1:0]                htrans,
	input  wire logic                      hwrite,
	input  wire logic [2:0]                hsize,
	input  wire logic [31:0]               hwdata,
	input  wire logic                      hready,
	output logic                           hreadyout,
	output logic                           hresp,
	output logic [31:0]                    hrdata,
	input  wire logic [7:0]                rx_status_a,
	input  wire logic [7:0]                rx_status_b,
	input  wire logic [7:0]                byte_count_a,
	input  wire logic [7:0]                byte_count_b,
	input  wire logic [scrbk_pkg::PEND_W-1:0] interrupt_pending,
	output logic                           irq
);
	import scrbk_pkg::*;

	// ----------------------------------------------------------------
	// Bus front end
	// ----------------------------------------------------------------
	logic              rd_en;
	logic              wr_en;
	logic [ADDR_W-1:0] wr_addr;
	logic [ADDR_W-1:0] rd_off;
	logic              rd_ch;
	logic [ADDR_W-1:0] wr_off;
	logic              wr_ch;

	scrbk_ahb_slave u_slave (
		.hclk      (hclk),
		.hresetn   (hresetn),
		.hsel      (hsel),
		.haddr     (haddr[ADDR_W-1:0]),
		.htrans    (htrans),
		.hwrite    (hwrite),
		.hready    (hready),
		.hreadyout (hreadyout),
		.hresp     (hresp),
		.rd_en     (rd_en),
		.wr_en     (wr_en),
		.wr_addr   (wr_addr)
	);

	function automatic logic [ADDR_W-1:0] strip_ch(input logic [ADDR_W-1:0] a);
		logic [ADDR_W-1:0] r;
		r = a;
		r[CHAN_B_BIT] = 1'b0;
		return r;
	endfunction

	always_comb begin
		rd_off = strip_ch(haddr[ADDR_W-1:0]);
		rd_ch  = haddr[CHAN_B_BIT];
		wr_off = strip_ch(wr_addr);
		wr_ch  = wr_addr[CHAN_B_BIT];
	end

	// ----------------------------------------------------------------
	// Configuration store
	// ----------------------------------------------------------------
	logic [7:0] mode_cfg [2];
	logic [7:0] txp_cfg  [2];
	logic [7:0] rxp_cfg  [2];
	logic [7:0] misc_cfg [2];
	logic [7:0] ext_cfg  [2];
	logic [7:0] vector;
	logic [7:0] next_mode_cfg [2];
	logic [7:0] next_txp_cfg  [2];
	logic [7:0] next_rxp_cfg  [2];
	logic [7:0] next_misc_cfg [2];
	logic [7:0] next_ext_cfg  [2];
	logic [7:0] next_vector;

	always_comb begin
		for (int c = 0; c < 2; c++) begin
			next_mode_cfg[c] = mode_cfg[c];
			next_txp_cfg[c]  = txp_cfg[c];
			next_rxp_cfg[c]  = rxp_cfg[c];
			next_misc_cfg[c] = misc_cfg[c];
			next_ext_cfg[c]  = ext_cfg[c];
			if (wr_en && (wr_ch == c[0])) begin
				unique case (wr_off)
					OFF_MODE_WR: next_mode_cfg[c] = hwdata[7:0];
					OFF_TXP_WR:  next_txp_cfg[c]  = hwdata[7:0];
					OFF_RXP_WR:  next_rxp_cfg[c]  = hwdata[7:0];
					OFF_MISC_WR: next_misc_cfg[c] = hwdata[7:0];
					OFF_EXT_WR:  next_ext_cfg[c]  = hwdata[7:0];
					default: ;
				endcase
			end
		end
		// One vector serves both channels
		next_vector = (wr_en && wr_off == OFF_VEC_WR) ? hwdata[7:0] : vector;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			for (int c = 0; c < 2; c++) begin
				mode_cfg[c] <= RST_CFG;
				txp_cfg[c]  <= RST_CFG;
				rxp_cfg[c]  <= RST_CFG;
				misc_cfg[c] <= RST_CFG;
				ext_cfg[c]  <= RST_CFG;
			end
			vector <= RST_VEC;
		end else begin
			for (int c = 0; c < 2; c++) begin
				mode_cfg[c] <= next_mode_cfg[c];
				txp_cfg[c]  <= next_txp_cfg[c];
				rxp_cfg[c]  <= next_rxp_cfg[c];
				misc_cfg[c] <= next_misc_cfg[c];
				ext_cfg[c]  <= next_ext_cfg[c];
			end
			vector <= next_vector;
		end
	end

	// ----------------------------------------------------------------
	// Interrupt status and mask
	// ----------------------------------------------------------------
	logic [PEND_W-1:0] irq_status;
	logic [PEND_W-1:0] irq_mask;

	scrbk_irq u_irq (
		.hclk    (hclk),
		.hresetn (hresetn),
		.src     (interrupt_pending),
		.clr_we  (wr_en && wr_off == OFF_IRQ_STAT),
		.mask_we (wr_en && wr_off == OFF_IRQ_MASK),
		.wdata   (hwdata[PEND_W-1:0]),
		.status  (irq_status),
		.mask    (irq_mask),
		.irq     (irq)
	);

	// ----------------------------------------------------------------
	// Readback builders
	// ----------------------------------------------------------------
	function automatic logic [7:0] mode_rb(input logic [7:0] c);
		return {c[MODE_CLK_LO +: 2], c[MODE_SYNC_LO +: 2],
			c[MODE_STOP_LO +: 2], c[1:0]};
	endfunction

	function automatic logic [7:0] tx_rb(input logic [7:0] c);
		return {c[TX_DTR], c[TX_LEN_LO +: 2], c[TX_BRK], c[TX_EN],
			c[TX_CRC_SEL], c[TX_RTS], c[TX_CRC_EN]};
	endfunction

	// Highest priority source: channel A rx first, channel B ext last
	function automatic logic [2:0] vec_code(input logic [PEND_W-1:0] p);
		if (p[PEND_A_RX])
			return VST_A_RX;
		if (p[PEND_A_TX])
			return VST_A_TX;
		if (p[PEND_A_EXT])
			return VST_A_EXT;
		if (p[PEND_B_RX])
			return VST_B_RX;
		if (p[PEND_B_TX])
			return VST_B_TX;
		if (p[PEND_B_EXT])
			return VST_B_EXT;
		return VST_NONE;
	endfunction

	// ----------------------------------------------------------------
	// Read mux, sampled in the address phase so the data phase is steady
	// ----------------------------------------------------------------
	logic [7:0]  rx_stat;
	logic [7:0]  bcnt;
	logic        ext_on;
	logic [7:0]  rd_byte;
	logic [31:0] next_hrdata;

	always_comb begin
		rx_stat = rd_ch ? rx_status_b : rx_status_a;
		bcnt    = rd_ch ? byte_count_b : byte_count_a;
		ext_on  = ext_cfg[rd_ch][EXT_RB_EN];
		rd_byte = 8'h00;
		case (rd_off)
			OFF_RXSTAT: rd_byte = rx_stat;
			OFF_VECTOR: begin
				rd_byte = vector;
				if (rd_ch)
					rd_byte[VEC_STAT_LO +: 3] = vec_code(interrupt_pending);
			end
			OFF_PEND: begin
				if (!rd_ch)
					rd_byte = {2'h0, interrupt_pending};
				else
					rd_byte = 8'h00;
			end
			OFF_MODE_RB: rd_byte = ext_on ? mode_rb(mode_cfg[rd_ch]) : rx_stat;
			OFF_TX_RB:   rd_byte = ext_on ? tx_rb(txp_cfg[rd_ch]) : rx_stat;
			OFF_RXP_RB:  rd_byte = ext_on ? rxp_cfg[rd_ch] : rx_stat;
			OFF_MISC_RB: rd_byte = ext_on ? misc_cfg[rd_ch] : rx_stat;
			OFF_BCNT:    rd_byte = bcnt;
			OFF_MODE_WR: rd_byte = mode_cfg[rd_ch];
			OFF_EXT_WR:  rd_byte = ext_cfg[rd_ch];
			OFF_VEC_WR:  rd_byte = vector;
			OFF_IRQ_STAT: rd_byte = {2'h0, irq_status};
			OFF_IRQ_MASK: rd_byte = {2'h0, irq_mask};
			default: rd_byte = 8'h00;
		endcase
		// Data register only moves on an accepted read
		next_hrdata = rd_en ? {24'h000000, rd_byte} : hrdata;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			hrdata <= 32'h00000000;
		else
			hrdata <= next_hrdata;
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	sequence rd_at(logic [ADDR_W-1:0] off, logic ch);
		rd_en && rd_off == off && rd_ch == ch;
	endsequence

	sequence rd_ext(logic [ADDR_W-1:0] off, logic ch, logic on);
		rd_en && rd_off == off && rd_ch == ch
			&& ext_cfg[rd_ch][EXT_RB_EN] == on;
	endsequence

	vec_b_code_a: assert property (
		rd_at(OFF_VECTOR, 1'b1) |=> hrdata[3:1] == vec_code($past(interrupt_pending))
			&& hrdata[7:4] == $past(vector[7:4]))
		else $error("channel B vector lacks source code");

	vec_a_plain_a: assert property (
		rd_at(OFF_VECTOR, 1'b0) |=> hrdata == {24'h000000, $past(vector)})
		else $error("channel A vector modified");

	pend_b_zero_a: assert property (
		rd_at(OFF_PEND, 1'b1) |=> hrdata[5:0] == 6'h00)
		else $error("channel B pending not zero");

	pend_a_map_a: assert property (
		rd_at(OFF_PEND, 1'b0) |=> hrdata[7:0] == {2'h0, $past(interrupt_pending)})
		else $error("channel A pending bits misplaced");

	mode_clk_a: assert property (
		rd_ext(OFF_MODE_RB, 1'b0, 1'b1) |=>
			hrdata[7:6] == $past(mode_cfg[0][MODE_CLK_LO +: 2]))
		else $error("clock-rate field misplaced");

	mode_sync_a: assert property (
		rd_ext(OFF_MODE_RB, 1'b0, 1'b1) |=>
			hrdata[5:4] == $past(mode_cfg[0][MODE_SYNC_LO +: 2]))
		else $error("sync-mode field misplaced");

	mode_stop_a: assert property (
		rd_ext(OFF_MODE_RB, 1'b1, 1'b1) |=>
			hrdata[3:2] == $past(mode_cfg[1][MODE_STOP_LO +: 2]))
		else $error("stop-bit field misplaced");

	tx_len_a: assert property (
		rd_ext(OFF_TX_RB, 1'b0, 1'b1) |=>
			hrdata[6:5] == $past(txp_cfg[0][TX_LEN_LO +: 2]))
		else $error("tx length misplaced");

	tx_bits_a: assert property (
		rd_ext(OFF_TX_RB, 1'b1, 1'b1) |=>
			{hrdata[7], hrdata[4:3], hrdata[1:0]} ==
			{$past(txp_cfg[1][TX_DTR]), $past(txp_cfg[1][TX_BRK]),
			$past(txp_cfg[1][TX_EN]), $past(txp_cfg[1][TX_RTS]),
			$past(txp_cfg[1][TX_CRC_EN])})
		else $error("tx control bits misplaced");

	tx_crc_sel_a: assert property (
		rd_ext(OFF_TX_RB, 1'b0, 1'b1) |=>
			hrdata[2] == $past(txp_cfg[0][TX_CRC_SEL]))
		else $error("crc select misplaced");

	mirror_off_a: assert property (
		rd_ext(OFF_MODE_RB, 1'b0, 1'b0) |=>
			hrdata[7:0] == $past(rx_status_a))
		else $error("mirror did not show rx status");

	mirror_on_a: assert property (
		rd_ext(OFF_RXP_RB, 1'b1, 1'b1) |=>
			hrdata[7:0] == $past(rxp_cfg[1]))
		else $error("mirror did not show rx config");

	rd_steady_a: assert property (
		!rd_en |=> $stable(hrdata))
		else $error("read data moved without a read");

	rd_no_side_a: assert property (
		rd_en && !wr_en |=> $stable(ext_cfg[0]) && $stable(ext_cfg[1])
			&& $stable(vector) && $stable(irq_mask))
		else $error("read changed state");
endmodule
`default_nettype wire

// >>> dv/scrbk_engine_model.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// Serial engine stand-in: presents status levels on the clock
// ----------------------------------------------------------------
module scrbk_engine_model (
	input  wire logic       hclk,
	input  wire logic       hresetn,
	input  wire logic [7:0] want_rx_a,
	input  wire logic [7:0] want_rx_b,
	input  wire logic [7:0] want_bc_a,
	input  wire logic [7:0] want_bc_b,
	input  wire logic [5:0] want_pend,
	output logic      [7:0] rx_status_a,
	output logic      [7:0] rx_status_b,
	output logic      [7:0] byte_count_a,
	output logic      [7:0] byte_count_b,
	output logic      [5:0] pend
);
	// Registered, so every change lands just after an edge
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rx_status_a  <= 8'h00;
			rx_status_b  <= 8'h00;
			byte_count_a <= 8'h00;
			byte_count_b <= 8'h00;
			pend         <= 6'h00;
		end else begin
			rx_status_a  <= want_rx_a;
			rx_status_b  <= want_rx_b;
			byte_count_a <= want_bc_a;
			byte_count_b <= want_bc_b;
			pend         <= want_pend;
		end
	end
endmodule
`default_nettype wire

// >>> dv/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
	import scrbk_pkg::*;
	localparam logic [2:0] VCODE [6] = '{VST_B_EXT, VST_B_TX, VST_B_RX,
		VST_A_EXT, VST_A_TX, VST_A_RX};
	logic        hclk;
	logic        hresetn;
	logic        hsel;
	logic [31:0] haddr;
	logic [1:0]  htrans;
	logic        hwrite;
	logic [31:0] hwdata;
	logic        hreadyout;
	logic        hresp;
	logic [31:0] hrdata;
	logic        irq;
	logic [7:0]  rx_a, rx_b, bc_a, bc_b;
	logic [7:0]  want_rx_a, want_rx_b, want_bc_a, want_bc_b;
	logic [5:0]  pend;
	logic [5:0]  want_pend;
	logic [7:0]  v;
	logic [31:0] q;
	int          err_total;
	int          checks;
	int          cyc;

	scrbk_regs scrbk_regs_i (
		.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
		.hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
		.hrdata(hrdata), .rx_status_a(rx_a), .rx_status_b(rx_b),
		.byte_count_a(bc_a), .byte_count_b(bc_b),
		.interrupt_pending(pend), .irq(irq)
	);

	scrbk_engine_model scrbk_engine_model_i (
		.hclk(hclk), .hresetn(hresetn), .want_rx_a(want_rx_a),
		.want_rx_b(want_rx_b), .want_bc_a(want_bc_a),
		.want_bc_b(want_bc_b), .want_pend(want_pend),
		.rx_status_a(rx_a), .rx_status_b(rx_b), .byte_count_a(bc_a),
		.byte_count_b(bc_b), .pend(pend)
	);

	always #25 hclk = ~hclk;

	// ----------------------------------------------------------------
	// Bus and checking tasks
	// ----------------------------------------------------------------
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", checks, err_total);
		if (err_total == 0 && checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	task automatic chk(input string what, input logic [31:0] seen,
		input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			err_total++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic bus(input logic wr, input logic [31:0] a,
		input logic [31:0] d);
		@(posedge hclk);
		hsel   <= 1'b1;
		htrans <= HTRANS_NONSEQ;
		haddr  <= a;
		hwrite <= wr;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel   <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wr ? d : 32'h0;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		q = hrdata;
	endtask

	task automatic wr(input logic [31:0] a, input logic [7:0] d);
		bus(1'b1, a, {24'h0, d});
	endtask

	task automatic rd(input string what, input logic [31:0] a,
		input logic [7:0] exp);
		bus(1'b0, a, 32'h0);
		chk(what, q, {24'h0, exp});
	endtask

	// Pending change, then clear the sticky status it left when clr is set
	task automatic set_pend(input logic [5:0] p, input logic clr);
		@(posedge hclk);
		want_pend <= p;
		repeat (3) @(posedge hclk);
		if (clr) begin
			wr(OFF_IRQ_STAT, 8'h3F);
		end
	endtask

	// ----------------------------------------------------------------
	// Watchdog
	// ----------------------------------------------------------------
	always @(posedge hclk) begin
		cyc++;
		if (cyc == 20000) begin
			err_total++;
			wrap_up();
		end
	end

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		hclk = 1'b0;
		hresetn = 1'b0;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hwdata = 32'h0;
		want_rx_a = 8'h5A;
		want_rx_b = 8'hC3;
		want_bc_a = 8'h37;
		want_bc_b = 8'h91;
		want_pend = 6'h00;
		err_total = 0;
		checks = 0;
		cyc = 0;
		repeat (4) @(posedge hclk);
		hresetn <= 1'b1;
		chk("irq_reset", {31'h0, irq}, 32'h0);
		rd("rxstat_a", OFF_RXSTAT, 8'h5A);
		rd("rxstat_b", OFF_RXSTAT + 12'h100, 8'hC3);
		foreach (VCODE[k]) begin
			if (k < 4) begin
				v = k[1:0] == 0 ? OFF_MODE_RB[7:0] : k[1:0] == 1 ?
					OFF_TX_RB[7:0] : k[1:0] == 2 ? OFF_RXP_RB[7:0] :
					OFF_MISC_RB[7:0];
				rd("mirror_off_a", {24'h0, v}, 8'h5A);
				rd("mirror_off_b", {24'h1, v}, 8'hC3);
			end
		end
		rd("bcnt_a", OFF_BCNT, 8'h37);
		rd("bcnt_b", OFF_BCNT + 12'h100, 8'h91);
		// Readback on for channel A only
		wr(OFF_EXT_WR, 8'h40);
		for (int i = 0; i < 4; i++) begin
			v = {i[1:0], ~i[1:0], i[1:0], i[0], ~i[0]};
			wr(OFF_MODE_WR, v);
			rd("mode_rb", OFF_MODE_RB, v);
			v = {i[0], i[1:0], ~i[0], i[1], i[0], ~i[1], i[0]};
			wr(OFF_TXP_WR, v);
			rd("tx_rb", OFF_TX_RB, v);
		end
		wr(OFF_RXP_WR, 8'hB4);
		rd("rxp_rb", OFF_RXP_RB, 8'hB4);
		wr(OFF_MISC_WR, 8'h2D);
		rd("misc_rb", OFF_MISC_RB, 8'h2D);
		rd("mode_rb_b_off", OFF_MODE_RB + 12'h100, 8'hC3);
		wr(OFF_EXT_WR + 12'h100, 8'h40);
		wr(OFF_MODE_WR + 12'h100, 8'h6C);
		rd("mode_rb_b", OFF_MODE_RB + 12'h100, 8'h6C);
		wr(OFF_TXP_WR + 12'h100, 8'h9B);
		rd("tx_rb_b", OFF_TX_RB + 12'h100, 8'h9B);
		wr(OFF_RXP_WR + 12'h100, 8'h4E);
		rd("rxp_rb_b", OFF_RXP_RB + 12'h100, 8'h4E);
		rd("mode_rb_a", OFF_MODE_RB, 8'hCE);
		wr(OFF_EXT_WR, 8'h00);
		rd("mode_rb_off", OFF_MODE_RB, 8'h5A);
		// Read-only place ignores writes, reads leave state alone
		wr(OFF_RXSTAT, 8'hFF);
		rd("rxstat_ro", OFF_RXSTAT, 8'h5A);
		rd("mode_wr_rb", OFF_MODE_WR, 8'hCE);
		rd("unmapped", 32'h0FC, 8'h00);
		// Pending bits and vector status, one source at a time
		wr(OFF_VEC_WR, 8'hA5);
		foreach (VCODE[k]) begin
			set_pend(6'h00, 1'b1);
			set_pend(6'h01 << k, 1'b0);
			rd("pend_a", OFF_PEND, 8'h01 << k);
			rd("pend_b", OFF_PEND + 12'h100, 8'h00);
			rd("vec_a", OFF_VECTOR, 8'hA5);
			rd("vec_b", OFF_VECTOR + 12'h100, {4'hA, VCODE[k], 1'b1});
		end
		set_pend(6'h3F, 1'b0);
		rd("vec_prio", OFF_VECTOR + 12'h100, {4'hA, VST_A_RX, 1'b1});
		rd("pend_all", OFF_PEND, 8'h3F);
		rd("pend_again", OFF_PEND, 8'h3F);
		set_pend(6'h00, 1'b1);
		rd("vec_none", OFF_VECTOR + 12'h100, {4'hA, VST_NONE, 1'b1});
		// Interrupt: masked event, unmasked event, clear
		wr(OFF_IRQ_MASK, 8'h01);
		set_pend(6'h20, 1'b0);
		chk("irq_masked", {31'h0, irq}, 32'h0);
		rd("irq_stat1", OFF_IRQ_STAT, 8'h20);
		set_pend(6'h21, 1'b0);
		chk("irq_raised", {31'h0, irq}, 32'h1);
		rd("irq_stat2", OFF_IRQ_STAT, 8'h21);
		rd("irq_stat3", OFF_IRQ_STAT, 8'h21);
		wr(OFF_IRQ_STAT, 8'h01);
		repeat (2) @(posedge hclk);
		chk("irq_cleared", {31'h0, irq}, 32'h0);
		rd("irq_stat4", OFF_IRQ_STAT, 8'h20);
		rd("irq_mask", OFF_IRQ_MASK, 8'h01);
		chk("hresp", {31'h0, hresp}, 32'h0);
		wrap_up();
	end
endmodule
`default_nettype wire
